// File: bench/rtc_port_chk.sv
// Purpose: checks the control lines between both ends
// Assumes: one clock domain, small phase counts
// Notes: start pulse width fixed at 8 cycles here
`timescale 1ns/1ps
module rtc_port_chk
#(
    parameter int WAIT_CYC = 20,
    parameter int PROBE_CYC = 20
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // controller to device
    input wire logic lockN,
    input wire logic startN,
    input wire logic stopN,
    input wire logic [rtc_pkg::SEL_W-1:0] selN,
    // device to controller
    input wire logic testN,
    input wire logic itemActiveN,
    input wire logic passN,
    input wire logic lowFailN,
    input wire logic highFailN
);
    import rtc_pkg::*;
    // ************
    // helpers
    // ************
    logic [15:0] lowCnt_q;
    wire [2:0] judgeN = {passN, lowFailN, highFailN};
    wire [4:0] panel = ~selN;
    always_ff @(posedge sys_clk)
    begin
        if (srst || testN)
            lowCnt_q <= 16'h0000;
        else
            lowCnt_q <= lowCnt_q + 16'h0001;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // ************
    // assertions
    // ************
    property p_judge_excl;
        $onehot0(~judgeN);
    endproperty
    a_judge_excl: assert property (p_judge_excl)
        else $error("several judgement lines low");
    property p_item_in_test;
        !itemActiveN |-> !testN;
    endproperty
    a_item_in_test: assert property (p_item_in_test)
        else $error("item line low outside a test");
    property p_start_lock;
        !startN |-> !lockN;
    endproperty
    a_start_lock: assert property (p_start_lock)
        else $error("start low without lock");
    property p_sel_setup;
        $fell(startN) |-> $stable(selN) && panel >= PANEL_MIN
            && panel <= PANEL_MAX;
    endproperty
    a_sel_setup: assert property (p_sel_setup)
        else $error("select not settled or out of range");
    property p_pulse;
        $fell(startN) |-> !startN [*8];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("start pulse too short");
    property p_wait;
        $fell(itemActiveN) |-> lowCnt_q == 16'(WAIT_CYC);
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait phase length wrong");
    property p_seq_len;
        $rose(testN) && $past(stopN) |->
            lowCnt_q == 16'(WAIT_CYC + PROBE_CYC) && $rose(itemActiveN);
    endproperty
    a_seq_len: assert property (p_seq_len)
        else $error("sequence length wrong");
    property p_stop;
        !stopN && !lockN && !testN |=> testN && itemActiveN;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not abort");
    property p_judge_end;
        $rose(testN) && $past(stopN) |-> $onehot(~judgeN);
    endproperty
    a_judge_end: assert property (p_judge_end)
        else $error("no judgement at end");
    c_start: cover property ($fell(testN));
    c_item: cover property ($fell(itemActiveN));
    c_abort: cover property (!stopN && !testN);
    c_lowfail: cover property ($rose(testN) && !lowFailN);
endmodule

// File: bench/testbench.sv
// Purpose: self-checking bench for both ends of the control port
// Assumes: short phase counts, run of a few hundred cycles
// Notes: second device end driven directly for three refused starts, one accepted start and a stop
`timescale 1ns/1ps
`define CHK(n, e, s) begin totalChecks++; if ((s) !== (e)) begin \
badCount++; $display("Error %s expected %0h seen %0h", n, e, s); end end
`define WAITFOR(c) for (int k = 0; k < 300 && !(c); k++) \
@(posedge sys_clk) #1;
module testbench;
    import rtc_pkg::*;
    localparam int PC = 8;
    logic sys_clk, srst, hsel, hwrite, hready, hresp, irq;
    logic linkUp, judgeLow, judgeHigh, remoteInd, panelLoad;
    logic measuring, aborted;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [4:0] panelNum, panelNumB;
    int badCount, totalChecks, cyc;
    // ************
    // design
    // ************
    rtc_port_if port();
    rtc_port_if portB();
    wire [2:0] judgeSeen = {port.passN, port.lowFailN, port.highFailN};
    wire [7:0] idleIn = {port.lockN, port.startN, port.stopN, port.selN};
    rtc_device #(.START_CYC(PC), .WAIT_CYC(20), .PROBE_CYC(20)) i_rtc_device
        (.sys_clk(sys_clk), .srst(srst), .port(port), .linkUp(linkUp),
        .judgeLow(judgeLow), .judgeHigh(judgeHigh), .remoteInd(remoteInd),
        .panelNum(panelNum), .panelLoad(panelLoad), .measuring(measuring),
        .aborted(aborted));
    rtc_device #(.START_CYC(PC), .WAIT_CYC(20), .PROBE_CYC(20)) i_rtc_device_b
        (.sys_clk(sys_clk), .srst(srst), .port(portB), .linkUp(linkUp),
        .judgeLow(judgeLow), .judgeHigh(judgeHigh), .remoteInd(),
        .panelNum(panelNumB), .panelLoad(), .measuring(), .aborted());
    rtc_ctrl #(.PULSE_CYC(PC)) i_rtc_ctrl
        (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .irq(irq), .port(port));
    rtc_port_chk #(.WAIT_CYC(20), .PROBE_CYC(20)) i_rtc_port_chk
        (.sys_clk(sys_clk), .srst(srst), .lockN(port.lockN),
        .startN(port.startN), .stopN(port.stopN), .selN(port.selN),
        .testN(port.testN), .itemActiveN(port.itemActiveN),
        .passN(port.passN), .lowFailN(port.lowFailN),
        .highFailN(port.highFailN));
    // ************
    // tasks
    // ************
    task endSim();
        $display("checks %0d errors %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task runPanel(input logic [4:0] pn, input logic jl, input logic jh,
        input logic [2:0] expJ);
        @(posedge sys_clk);
        judgeLow <= jl;
        judgeHigh <= jh;
        ahb(1'b1, ADDR_IRQ_EN, 32'h00000007);
        ahb(1'b1, ADDR_CTRL, {19'h00000, pn, 8'h03});
        `WAITFOR(port.startN === 1'b0)
        `CHK("selN", ~pn, port.selN)
        `CHK("lockN", 1'b0, port.lockN)
        `WAITFOR(port.testN === 1'b0)
        `CHK("panelNum", pn, panelNum)
        `CHK("panelLoad", 1'b1, panelLoad)
        `WAITFOR(port.itemActiveN === 1'b0)
        `CHK("measuring", 1'b1, measuring)
        ahb(1'b0, ADDR_STATUS, 32'h00000000);
        `CHK("status", 32'h00000046, rd)
        `CHK("hresp", 1'b0, hresp)
        `WAITFOR(port.testN === 1'b1)
        `CHK("judge", expJ, judgeSeen)
        repeat (3) @(posedge sys_clk);
        ahb(1'b0, ADDR_IRQ_STAT, 32'h00000000);
        `CHK("irqStat", 32'h00000003, rd)
        `CHK("irqUp", 1'b1, irq)
        ahb(1'b1, ADDR_IRQ_CLR, 32'h00000007);
        repeat (2) @(posedge sys_clk) #1;
        `CHK("irqClr", 1'b0, irq)
    endtask
    task abortRun();
        ahb(1'b1, ADDR_CTRL, 32'h00000203);
        `WAITFOR(port.itemActiveN === 1'b0)
        ahb(1'b1, ADDR_CTRL, 32'h00000205);
        `WAITFOR(aborted === 1'b1)
        `CHK("aborted", 1'b1, aborted)
        `CHK("abortTest", 2'h3, {port.testN, port.itemActiveN})
        `CHK("abortJudge", 3'h7, judgeSeen)
        ahb(1'b0, ADDR_IRQ_STAT, 32'h00000000);
        `CHK("abortStat", 32'h00000003, rd)
        ahb(1'b1, ADDR_IRQ_CLR, 32'h00000007);
    endtask
    task refuse();
        ahb(1'b1, ADDR_IRQ_EN, 32'h00000000);
        ahb(1'b1, ADDR_CTRL, 32'h00001F03);
        ahb(1'b1, ADDR_CTRL, 32'h00000003);
        ahb(1'b1, ADDR_CTRL, 32'h00000202);
        repeat (PC + 6) @(posedge sys_clk) #1;
        `CHK("noStart", 1'b1, port.testN)
        `CHK("irqMasked", 1'b0, irq)
        ahb(1'b0, ADDR_IRQ_STAT, 32'h00000000);
        `CHK("refused", 32'h00000004, rd)
        ahb(1'b1, ADDR_IRQ_EN, 32'h00000004);
        repeat (2) @(posedge sys_clk) #1;
        `CHK("irqEn", 1'b1, irq)
        ahb(1'b1, ADDR_IRQ_CLR, 32'h00000004);
        ahb(1'b0, 8'h40, 32'h00000000);
        `CHK("unmapped", 32'h00000000, rd)
        `CHK("irqOff", 1'b0, irq)
    endtask
    task driveB(input logic lk, input logic [4:0] sel, input logic expT);
        @(posedge sys_clk);
        portB.lockN <= lk;
        portB.selN <= sel;
        @(posedge sys_clk);
        portB.startN <= 1'b0;
        repeat (PC + 2) @(posedge sys_clk);
        portB.startN <= 1'b1;
        #1;
        `CHK("devTest", expT, portB.testN)
        `CHK("devPanel", expT ? PANEL_RST : ~sel, panelNumB)
    endtask
    // ************
    // sequence
    // ************
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            badCount++;
            endSim();
        end
    end
    initial
    begin
        {srst, linkUp, judgeLow, judgeHigh, hsel, hwrite} = 6'h20;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        {portB.lockN, portB.startN, portB.stopN, portB.selN} = 8'hFF;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk) #1;
        `CHK("idleIn", 8'hFF, idleIn)
        `CHK("idleOut", 2'h3, {port.testN, port.itemActiveN})
        `CHK("remoteOff", 1'b0, remoteInd)
        linkUp <= 1'b1;
        repeat (2) @(posedge sys_clk) #1;
        `CHK("remoteOn", 1'b1, remoteInd)
        runPanel(5'h01, 1'b0, 1'b0, 3'h3);
        runPanel(5'h1E, 1'b1, 1'b0, 3'h5);
        runPanel(5'h10, 1'b0, 1'b1, 3'h6);
        runPanel(5'h05, 1'b1, 1'b1, 3'h5);
        abortRun();
        refuse();
        driveB(1'b0, 5'h1F, 1'b1);
        driveB(1'b0, 5'h00, 1'b1);
        driveB(1'b1, 5'h1D, 1'b1);
        driveB(1'b0, 5'h1D, 1'b0);
        portB.stopN <= 1'b0;
        repeat (2) @(posedge sys_clk) #1;
        `CHK("devStop", 1'b1, portB.testN)
        endSim();
    end
endmodule

// File: inc/rtc_pkg.sv
// Purpose: shared constants of the remote test control port
// Assumes: sys_clk at 250 MHz, all port lines synchronous to it
// Notes: active-low lines carry the suffix N
//
// Summary of operation
// - select lines carry complemented panel number
// - lock, start, stop, select asserted low
// - link up shows remote, lock honoured
// - control only while locked; select before start
// - start held low at least 1 ms
// - wait 1 s then measure 1 s
// - item line low while measuring item
// - pass, low-fail, high-fail outputs active low
// - stop aborts measurement in progress
package rtc_pkg;
    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int START_MIN_MS = 1;
    localparam int WAIT_MIN_S = 1;
    localparam int PROBE_MIN_S = 1;
    localparam int SEQ_MIN_S = 2;
    localparam int START_MIN_CYC = START_MIN_MS * 1000000 / CLK_PERIOD_NS;
    localparam int WAIT_MIN_CYC = WAIT_MIN_S * 1000000000 / CLK_PERIOD_NS;
    localparam int PROBE_MIN_CYC = PROBE_MIN_S * 1000000000 / CLK_PERIOD_NS;
    localparam int CNT_W = 28;
    // ************************************************
    // panel select
    // ************************************************
    localparam int SEL_W = 5;
    localparam logic [4:0] PANEL_MIN = 5'h01;
    localparam logic [4:0] PANEL_MAX = 5'h1E;
    // ************************************************
    // controller registers
    // ************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    localparam int CTRL_LOCK = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_STOP = 2;
    localparam int CTRL_PANEL = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_TESTING = 1;
    localparam int ST_MEASURING = 2;
    localparam int ST_PASS = 3;
    localparam int ST_LOWFAIL = 4;
    localparam int ST_HIGHFAIL = 5;
    localparam int ST_LOCKED = 6;
    localparam int IRQ_W = 3;
    localparam int IRQ_TEST_BEGIN = 0;
    localparam int IRQ_TEST_END = 1;
    localparam int IRQ_REFUSED = 2;
    localparam logic [4:0] PANEL_RST = 5'h01;
endpackage

// File: inc/rtc_port_if.sv
`timescale 1ns/1ps
// Purpose: discrete control lines between controller and instrument
// Assumes: both ends on sys_clk
// Notes: every line is active low
interface rtc_port_if;
    logic lockN;
    logic startN;
    logic stopN;
    logic [rtc_pkg::SEL_W-1:0] selN;
    logic testN;
    logic itemActiveN;
    logic passN;
    logic lowFailN;
    logic highFailN;
    modport device
    (
        input lockN, startN, stopN, selN,
        output testN, itemActiveN, passN, lowFailN, highFailN
    );
    modport ctrl
    (
        output lockN, startN, stopN, selN,
        input testN, itemActiveN, passN, lowFailN, highFailN
    );
endinterface

// File: verilog/rtc_ctrl.sv
`timescale 1ns/1ps
// Purpose: automation controller end, ordered over AHB-Lite
// Assumes: zero wait state slave, single word transfers
// Notes: start and stop pulses last PULSE_CYC cycles
module rtc_ctrl
#(
    parameter int PULSE_CYC = rtc_pkg::START_MIN_CYC
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // interrupt
    output logic irq,
    // control port
    rtc_port_if.ctrl port
);
    import rtc_pkg::*;

    typedef enum logic [1:0] {P_IDLE, P_SETUP, P_START, P_STOP}
        rtc_pulse_state_t;

    rtc_pulse_state_t ps_q, ps_d;
    logic [CNT_W-1:0] cnt_q;
    logic lock_q, lockN_q, startN_q, stopN_q;
    logic [SEL_W-1:0] panel_q, selN_q;
    logic [IRQ_W-1:0] irqStat_q, irqStat_d, irqEn_q;
    logic irq_q, testPrev_q, dWr_q;
    logic [7:0] dAddr_q;
    logic [31:0] rdata_q, rdMux;

    // ************************************************
    // bus decode
    // ************************************************
    wire addrPhase = hsel && htrans[1] && hready;
    wire wrCtrl = dWr_q && (dAddr_q == ADDR_CTRL);
    wire wrClr = dWr_q && (dAddr_q == ADDR_IRQ_CLR);
    wire wrEn = dWr_q && (dAddr_q == ADDR_IRQ_EN);
    wire [SEL_W-1:0] wrPanel = hwdata[CTRL_PANEL +: SEL_W];
    wire wrPanelOk = (wrPanel >= PANEL_MIN) &&
                     (wrPanel <= PANEL_MAX);
    wire reqStart = wrCtrl && hwdata[CTRL_START];
    wire reqStop = wrCtrl && hwdata[CTRL_STOP];
    wire goStart = reqStart && !reqStop && wrPanelOk &&
                   hwdata[CTRL_LOCK] && (ps_q == P_IDLE);
    wire refused = reqStart && !reqStop && !goStart;
    wire pulseEnd = cnt_q == CNT_W'(PULSE_CYC - 1);

    wire [31:0] ctrlRd = {19'h0, panel_q, 7'h0, lock_q};
    wire [6:0] statBits = {lock_q, !port.highFailN, !port.lowFailN,
                           !port.passN, !port.itemActiveN, !port.testN,
                           ps_q != P_IDLE};
    wire [31:0] statRd = {25'h0, statBits};

    always_comb
    begin
        rdMux = 32'h0;
        unique case (haddr[7:0])
            ADDR_CTRL: rdMux = ctrlRd;
            ADDR_STATUS: rdMux = statRd;
            ADDR_IRQ_STAT: rdMux = {29'h0, irqStat_q};
            ADDR_IRQ_EN: rdMux = {29'h0, irqEn_q};
            default: rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            dWr_q <= 1'b0;
            dAddr_q <= 8'h00;
            rdata_q <= 32'h0;
        end
        else
        begin
            dWr_q <= addrPhase && hwrite;
            dAddr_q <= haddr[7:0];
            if (addrPhase && !hwrite)
            begin
                rdata_q <= rdMux;
            end
        end
    end

    // ************************************************
    // pulse sequencer
    // ************************************************
    always_comb
    begin
        ps_d = ps_q;
        unique case (ps_q)
            P_IDLE:
            begin
                if (reqStop)
                begin
                    ps_d = P_STOP;
                end
                else if (goStart)
                begin
                    ps_d = P_SETUP;
                end
            end
            P_SETUP:
            begin
                ps_d = reqStop ? P_STOP : P_START;
            end
            P_START, P_STOP:
            begin
                if (reqStop && ps_q == P_START)
                begin
                    ps_d = P_STOP;
                end
                else if (pulseEnd)
                begin
                    ps_d = P_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            ps_q <= P_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            ps_q <= ps_d;
            cnt_q <= (ps_d != ps_q) ? '0 : cnt_q + CNT_W'(1);
        end
    end

    // ************************************************
    // registers and port lines
    // ************************************************
    assign irqStat_d = (irqStat_q & ~(wrClr ? hwdata[IRQ_W-1:0] : '0)) |
                       {refused, port.testN && !testPrev_q,
                        !port.testN && testPrev_q};

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            lock_q <= 1'b0;
            panel_q <= PANEL_RST;
            irqEn_q <= '0;
            irqStat_q <= '0;
            irq_q <= 1'b0;
            testPrev_q <= 1'b1;
            lockN_q <= 1'b1;
            startN_q <= 1'b1;
            stopN_q <= 1'b1;
            selN_q <= '1;
        end
        else
        begin
            if (wrCtrl)
            begin
                lock_q <= hwdata[CTRL_LOCK];
                panel_q <= wrPanel;
            end
            if (wrEn)
            begin
                irqEn_q <= hwdata[IRQ_W-1:0];
            end
            irqStat_q <= irqStat_d;
            irq_q <= |(irqStat_d & irqEn_q);
            testPrev_q <= port.testN;
            lockN_q <= !(wrCtrl ? hwdata[CTRL_LOCK] : lock_q);
            if (goStart)
            begin
                selN_q <= ~wrPanel;
            end
            startN_q <= ps_d != P_START;
            stopN_q <= ps_d != P_STOP;
        end
    end

    assign port.lockN = lockN_q;
    assign port.startN = startN_q;
    assign port.stopN = stopN_q;
    assign port.selN = selN_q;
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = irq_q;
endmodule

// File: verilog/rtc_device.sv
`timescale 1ns/1ps
// Purpose: instrument end of the remote test control port
// Assumes: port lines synchronous to sys_clk
// Notes: judgement inputs sampled at end of measuring phase
module rtc_device
#(
    parameter int START_CYC = rtc_pkg::START_MIN_CYC,
    parameter int WAIT_CYC = rtc_pkg::WAIT_MIN_CYC,
    parameter int PROBE_CYC = rtc_pkg::PROBE_MIN_CYC
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // control port
    rtc_port_if.device port,
    // instrument side
    input wire logic linkUp,
    input wire logic judgeLow,
    input wire logic judgeHigh,
    output logic remoteInd,
    output logic [rtc_pkg::SEL_W-1:0] panelNum,
    output logic panelLoad,
    output logic measuring,
    output logic aborted
);
    import rtc_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_PROBE} rtc_dev_state_t;

    rtc_dev_state_t st_q, st_d;
    logic [CNT_W-1:0] startCnt_q, startCnt_d;
    logic [CNT_W-1:0] phCnt_q, phCnt_d;
    logic remote_q;
    logic [SEL_W-1:0] panel_q;
    logic panelLoad_q, aborted_q;
    logic testN_q, itemN_q, passN_q, lowN_q, highN_q, measuring_q;

    // ************************************************
    // decode
    // ************************************************
    wire enabled = remote_q && !port.lockN;
    wire [SEL_W-1:0] selCode = ~port.selN;
    wire selValid = (selCode >= PANEL_MIN) &&
                    (selCode <= PANEL_MAX);
    wire startLow = enabled && !port.startN;
    wire startHit = startLow &&
                    (startCnt_q == CNT_W'(START_CYC - 1));
    wire stopHit = enabled && !port.stopN;
    wire waitDone = phCnt_q == CNT_W'(WAIT_CYC - 1);
    wire probeDone = phCnt_q == CNT_W'(PROBE_CYC - 1);
    wire busy = st_q != S_IDLE;
    wire doAbort = busy && stopHit;
    wire doStart = (st_q == S_IDLE) && startHit && selValid;
    wire doJudge = (st_q == S_PROBE) && probeDone && !stopHit;

    // ************************************************
    // start pulse width filter
    // ************************************************
    always_comb
    begin
        if (!startLow)
        begin
            startCnt_d = '0;
        end
        else if (startCnt_q == CNT_W'(START_CYC))
        begin
            startCnt_d = startCnt_q;
        end
        else
        begin
            startCnt_d = startCnt_q + CNT_W'(1);
        end
    end

    // ************************************************
    // sequence
    // ************************************************
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            S_IDLE:
            begin
                if (doStart)
                begin
                    st_d = S_WAIT;
                end
            end
            S_WAIT:
            begin
                if (stopHit)
                begin
                    st_d = S_IDLE;
                end
                else if (waitDone)
                begin
                    st_d = S_PROBE;
                end
            end
            S_PROBE:
            begin
                if (stopHit || probeDone)
                begin
                    st_d = S_IDLE;
                end
            end
        endcase
    end

    assign phCnt_d = (st_d != st_q) ? '0 : phCnt_q + CNT_W'(1);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            st_q <= S_IDLE;
            startCnt_q <= '0;
            phCnt_q <= '0;
            remote_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            startCnt_q <= startCnt_d;
            phCnt_q <= busy ? phCnt_d : '0;
            remote_q <= linkUp;
        end
    end

    // ************************************************
    // panel latch and event pulses
    // ************************************************
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            panel_q <= PANEL_RST;
            panelLoad_q <= 1'b0;
            aborted_q <= 1'b0;
        end
        else
        begin
            if (doStart)
            begin
                panel_q <= selCode;
            end
            panelLoad_q <= doStart;
            aborted_q <= doAbort;
        end
    end

    // ************************************************
    // port outputs
    // ************************************************
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            testN_q <= 1'b1;
            itemN_q <= 1'b1;
            passN_q <= 1'b1;
            lowN_q <= 1'b1;
            highN_q <= 1'b1;
            measuring_q <= 1'b0;
        end
        else
        begin
            testN_q <= st_d == S_IDLE;
            itemN_q <= st_d != S_PROBE;
            measuring_q <= st_d == S_PROBE;
            if (doStart || doAbort)
            begin
                passN_q <= 1'b1;
                lowN_q <= 1'b1;
                highN_q <= 1'b1;
            end
            else if (doJudge)
            begin
                passN_q <= judgeLow || judgeHigh;
                lowN_q <= !judgeLow;
                highN_q <= !judgeHigh || judgeLow;
            end
        end
    end

    assign port.testN = testN_q;
    assign port.itemActiveN = itemN_q;
    assign port.passN = passN_q;
    assign port.lowFailN = lowN_q;
    assign port.highFailN = highN_q;
    assign remoteInd = remote_q;
    assign panelNum = panel_q;
    assign panelLoad = panelLoad_q;
    assign measuring = measuring_q;
    assign aborted = aborted_q;
endmodule
